// ---- coefficient_ram_block_addressing.v ----
`include "coef_map_defines.vh"

module coefficient_ram_block_addressing (
  // clock and reset
  input wire clock,
  input wire rst,
  // command from the control interface
  input wire cmd_valid,
  input wire cmd_write,
  input wire [`COEF_CODE_W-1:0] cmd_block,
  // write data, one word per accepted beat
  input wire wr_valid,
  input wire [`COEF_DATA_W-1:0] wr_data,
  // read data towards the control interface
  output reg rd_valid_q,
  output reg [`COEF_DATA_W-1:0] rd_data_q,
  // sequence status
  output reg busy_q,
  output reg done_q,
  output reg rejected_q,
  output reg [`COEF_ADDR_W-1:0] word_addr_q,
  // coefficient taps for the filter engine
  output reg [`COEF_DATA_W-1:0] tone1_amplitude_q,
  output reg [`COEF_DATA_W-1:0] tone1_frequency_q,
  output reg [`COEF_DATA_W-1:0] tone0_amplitude_q,
  output reg [`COEF_DATA_W-1:0] tone0_frequency_q
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WRITE = 2'h1;
  localparam [1:0] ST_READ = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`COEF_CODE_W-1:0] block_q;
  reg [`COEF_CODE_W-1:0] block_d;
  reg [`COEF_INDEX_W-1:0] index_q;
  reg [`COEF_INDEX_W-1:0] index_d;

  wire [`COEF_ADDR_W-1:0] cur_addr;
  wire [`COEF_DATA_W-1:0] cells [0:`COEF_WORDS-1];
  wire [`COEF_WORDS-1:0] cell_we;
  wire write_beat;
  wire last_word;
  reg cmd_ok;
  reg [`COEF_DATA_W-1:0] read_word;

  // location is code over internally generated index
  assign cur_addr = {block_q, index_q};
  assign write_beat = (state_q == ST_WRITE) && wr_valid;
  assign last_word = (index_q == `COEF_INDEX_BOTTOM);

  // ------------------------------------------------------------
  // block decode
  // ------------------------------------------------------------
  // unallocated codes must never reach the sequencer
  always @* begin
    cmd_ok = 1'b0;
    if (cmd_block == `BLK_IMPEDANCE_FILTER) begin
      cmd_ok = 1'b1;
    end else if (cmd_block == `BLK_ECHO_FILTER) begin
      cmd_ok = 1'b1;
    end else if (cmd_block == `BLK_SCALING_TONE) begin
      cmd_ok = 1'b1;
    end else if (cmd_block == `BLK_TRANSMIT) begin
      cmd_ok = 1'b1;
    end else if (cmd_block == `BLK_RECEIVE) begin
      // gain and frequency halves share this one code
      cmd_ok = 1'b1;
    end else begin
      cmd_ok = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `COEF_WORDS; gi = gi + 1) begin : g_word
      // one-hot enable; no cell answers a location past word 39
      assign cell_we[gi] = write_beat && (cur_addr == gi[`COEF_ADDR_W-1:0]);
      coef_word_cell u_cell (
        .clock(clock),
        .rst(rst),
        .write_en(cell_we[gi]),
        .write_data(wr_data),
        .value_q(cells[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @* begin
    state_d = state_q;
    block_d = block_q;
    index_d = index_q;
    case (state_q)
      ST_IDLE: begin
        // the word index always starts from the top, never from the host
        if (cmd_valid && cmd_ok) begin
          block_d = cmd_block;
          index_d = `COEF_INDEX_TOP;
          state_d = cmd_write ? ST_WRITE : ST_READ;
        end
      end
      ST_WRITE: begin
        // stalls on missing data so no word is skipped
        if (wr_valid) begin
          if (last_word) begin
            state_d = ST_IDLE;
          end else begin
            index_d = index_q - 3'h1;
          end
        end
      end
      ST_READ: begin
        // no stall: each cycle hands one word out
        if (last_word) begin
          state_d = ST_IDLE;
        end else begin
          index_d = index_q - 3'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      block_q <= 3'h0;
      index_q <= 3'h0;
    end else begin
      state_q <= state_d;
      block_q <= block_d;
      index_q <= index_d;
    end
  end

  // ------------------------------------------------------------
  // read select
  // ------------------------------------------------------------
  // guard keeps an out-of-range location from reading an unknown word
  always @* begin
    if (state_q != ST_READ) begin
      read_word = 16'h0000;
    end else if (cur_addr < `COEF_WORDS) begin
      read_word = cells[cur_addr];
    end else begin
      read_word = 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 16'h0000;
      word_addr_q <= 6'h00;
    end else begin
      rd_valid_q <= (state_q == ST_READ);
      // block 100 returns receive gain words then receive frequency words
      rd_data_q <= read_word;
      word_addr_q <= cur_addr;
    end
  end

  // ------------------------------------------------------------
  // sequence status
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rejected_q <= 1'b0;
    end else begin
      busy_q <= (state_d != ST_IDLE);
      // last read word and done share one edge
      done_q <= (state_q != ST_IDLE) && (state_d == ST_IDLE);
      // unallocated code: nothing stored, nothing returned
      rejected_q <= (state_q == ST_IDLE) && cmd_valid && !cmd_ok;
    end
  end

  // ------------------------------------------------------------
  // tone taps
  // ------------------------------------------------------------
  // taps are registered so the filter side sees stable words
  always @(posedge clock) begin
    if (rst) begin
      tone1_amplitude_q <= 16'h0000;
      tone1_frequency_q <= 16'h0000;
      tone0_amplitude_q <= 16'h0000;
      tone0_frequency_q <= 16'h0000;
    end else begin
      tone1_amplitude_q <= cells[`WORD_TONE1_AMPLITUDE];
      tone1_frequency_q <= cells[`WORD_TONE1_FREQUENCY];
      tone0_amplitude_q <= cells[`WORD_TONE0_AMPLITUDE];
      tone0_frequency_q <= cells[`WORD_TONE0_FREQUENCY];
    end
  end

  // block map is fixed by cur_addr: code*8+index selects cell
endmodule

// ---- coef_map_defines.vh ----
`ifndef COEF_MAP_DEFINES_VH
`define COEF_MAP_DEFINES_VH

// ------------------------------------------------------------
// memory geometry
// ------------------------------------------------------------
`define COEF_WORDS 40
`define COEF_BLOCKS 5
`define COEF_BLOCK_LEN 8
`define COEF_ADDR_W 6
`define COEF_CODE_W 3
`define COEF_INDEX_W 3
`define COEF_DATA_W 16
`define COEF_INDEX_TOP 3'h7
`define COEF_INDEX_BOTTOM 3'h0

// ------------------------------------------------------------
// block codes
// ------------------------------------------------------------
`define BLK_IMPEDANCE_FILTER 3'h0
`define BLK_ECHO_FILTER 3'h1
`define BLK_SCALING_TONE 3'h2
`define BLK_TRANSMIT 3'h3
`define BLK_RECEIVE 3'h4
`define BLK_LAST_VALID 3'h4

// ------------------------------------------------------------
// fixed word locations
// ------------------------------------------------------------
`define WORD_TONE1_AMPLITUDE 6'h17
`define WORD_TONE1_FREQUENCY 6'h16
`define WORD_TONE0_AMPLITUDE 6'h15
`define WORD_TONE0_FREQUENCY 6'h14

`endif

// ---- coef_word_cell.v ----
`include "coef_map_defines.vh"

// one coefficient word of storage
module coef_word_cell (
  // clock and reset
  input wire clock,
  input wire rst,
  // write side
  input wire write_en,
  input wire [`COEF_DATA_W-1:0] write_data,
  // stored value
  output reg [`COEF_DATA_W-1:0] value_q
);

  always @(posedge clock) begin
    if (rst) begin
      value_q <= {`COEF_DATA_W{1'b0}};
    end else if (write_en) begin
      value_q <= write_data;
    end
  end

endmodule

// ---- coef_addr_checker.sv ----
module coef_addr_checker (
  // clock and reset
  input wire clock,
  input wire rst,
  // command and results
  input wire cmd_valid,
  input wire cmd_write,
  input wire [2:0] cmd_block,
  input wire rd_valid_q,
  input wire [15:0] rd_data_q,
  input wire busy_q,
  input wire done_q,
  input wire rejected_q,
  input wire [5:0] word_addr_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire take = cmd_valid && !busy_q;
  a_reject_pulse: assert property (take && cmd_block > 3'h4 |=> rejected_q && !busy_q) else $error("no reject");
  a_reject_quiet: assert property (rejected_q |-> !rd_valid_q && !busy_q && !done_q) else $error("reject ran");
  a_read_walk: assert property (take && !cmd_write && cmd_block < 3'h5 |=>
    busy_q ##1 (rd_valid_q && busy_q) [*7] ##1 (rd_valid_q && done_q && !busy_q)) else $error("bad read walk");
  a_first_word: assert property ($rose(rd_valid_q) |-> word_addr_q[2:0] == 3'h7) else $error("not top");
  a_count_down: assert property (rd_valid_q && $past(rd_valid_q) |->
    word_addr_q == $past(word_addr_q) - 6'h1) else $error("index step");
  a_addr_range: assert property (rd_valid_q |-> word_addr_q < 6'h28) else $error("addr range");
  a_data_idle: assert property (!rd_valid_q |-> rd_data_q == 16'h0000) else $error("idle data");
  a_done_single: assert property (done_q |=> !done_q) else $error("done stuck");
endmodule
bind coefficient_ram_block_addressing coef_addr_checker u_coef_addr_checker (.clock(clock), .rst(rst),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_block(cmd_block), .rd_valid_q(rd_valid_q),
  .rd_data_q(rd_data_q), .busy_q(busy_q), .done_q(done_q), .rejected_q(rejected_q), .word_addr_q(word_addr_q));

// ---- host_word_feeder.sv ----
module host_word_feeder (
  // clock and control
  input wire clock,
  input wire go,
  input wire slow,
  input wire [2:0] blk,
  // write words
  output logic wr_valid,
  output logic [15:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] n = 4'h0;
  logic hold = 1'b0;
  initial wr_valid = 1'b0;
  initial wr_data = 16'h0000;
  // host knows only the block; index order is the device's
  always @(negedge clock) begin
    n = go ? n + {3'h0, wr_valid} : 4'h0;
    hold = slow & ~hold;
    wr_valid = go && n < 4'h8 && !hold;
    wr_data = wr_valid ? {10'h168, blk, ~n[2:0]} : ~wr_data;
  end
endmodule

// ---- coefficient_ram_block_addressing_tb.sv ----
module coefficient_ram_block_addressing_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0, wmode = 1'b0, slow = 1'b0;
  logic [2:0] cmd_block = 3'h0;
  logic wr_valid, rd_valid_q, busy_q, done_q, rejected_q;
  logic [15:0] wr_data, rd_data_q, t1a, t1f, t0a, t0f;
  logic [5:0] word_addr_q;
  int fails = 0, n_checks = 0;
  initial forever #10 clock = ~clock;
  coefficient_ram_block_addressing u_coefficient_ram_block_addressing (.clock(clock), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_block(cmd_block), .wr_valid(wr_valid),
    .wr_data(wr_data), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .busy_q(busy_q), .done_q(done_q),
    .rejected_q(rejected_q), .word_addr_q(word_addr_q), .tone1_amplitude_q(t1a), .tone1_frequency_q(t1f),
    .tone0_amplitude_q(t0a), .tone0_frequency_q(t0f));
  host_word_feeder u_host_word_feeder (.clock(clock), .go(wmode && busy_q), .slow(slow),
    .blk(cmd_block), .wr_valid(wr_valid), .wr_data(wr_data));
  function automatic logic [15:0] pat(input logic [5:0] a);
    return {10'h168, a};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic w, input logic [2:0] b);
    @(negedge clock);
    cmd_write = w;
    cmd_block = b;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask
  task automatic wait_done;
    for (int i = 0; i < 60 && done_q !== 1'b1; i++) @(negedge clock);
    if (done_q !== 1'b1) begin
      fails++;
      report_and_stop;
    end
  endtask
  // write every block, odd ones with a stalling host
  task automatic write_all;
    for (int b = 0; b < 5; b++) begin
      slow = b[0];
      wmode = 1'b1;
      cmd(1'b1, b[2:0]);
      wait_done;
      wmode = 1'b0;
    end
  endtask
  task automatic tone_taps;
    chk(t1a, pat(6'h17));
    chk(t1f, pat(6'h16));
    chk(t0a, pat(6'h15));
    chk(t0f, pat(6'h14));
  endtask
  task automatic reject_codes;
    for (int i = 0; i < 6; i++) begin
      cmd(i[0], 3'h5 + i[2:1]);
      chk({15'h0, rejected_q}, 16'h0001);
      chk({15'h0, busy_q}, 16'h0000);
      @(negedge clock);
      chk({15'h0, rd_valid_q}, 16'h0000);
    end
  endtask
  task automatic read_all;
    for (int b = 0; b < 5; b++) begin
      cmd(1'b0, b[2:0]);
      @(negedge clock);
      for (int i = 7; i >= 0; i--) begin
        chk({15'h0, rd_valid_q}, 16'h0001);
        chk(rd_data_q, pat({b[2:0], i[2:0]}));
        chk({10'h0, word_addr_q}, {10'h0, b[2:0], i[2:0]});
        chk({15'h0, done_q}, (i == 0) ? 16'h0001 : 16'h0000);
        @(negedge clock);
      end
      chk({15'h0, rd_valid_q}, 16'h0000);
      chk({15'h0, busy_q}, 16'h0000);
    end
  endtask
  initial begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    chk(t1a, 16'h0000);
    write_all;
    tone_taps;
    reject_codes;
    read_all;
    report_and_stop;
  end
endmodule
